// >>> hdl/compact_timer_pkg.sv
// package: register map, field layout and encodings of the compact timer
package compact_timer_pkg;

	// register indices on the plain port (byte registers)
	localparam logic [2:0] ADDR_CONTROL_A = 3'h0;
	localparam logic [2:0] ADDR_CONTROL_B = 3'h1;
	localparam logic [2:0] ADDR_COUNT_LOW = 3'h2;
	localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;
	localparam logic [2:0] ADDR_CMP_A_LOW = 3'h4;
	localparam logic [2:0] ADDR_CMP_A_HIGH = 3'h5;
	localparam logic [2:0] ADDR_CMP_P = 3'h6;

	// control A field positions
	localparam int CA_PAUSE_BIT = 7;
	localparam int CA_CLKSEL_LSB = 4;
	localparam int CA_ENABLE_BIT = 3;
	localparam logic [7:0] CA_WRITE_MASK = 8'hF8;

	// reset values
	localparam logic [7:0] CONTROL_A_RESET = 8'h00;
	localparam logic [7:0] CONTROL_B_RESET = 8'h00;
	localparam logic [15:0] CMP_A_RESET = 16'h0000;
	localparam logic [7:0] CMP_P_RESET = 8'h00;

	// prescale counts
	localparam int SYS_DIV = 4;
	localparam int HIGH_DIV_16 = 16;
	localparam int HIGH_DIV_64 = 64;

	typedef enum logic [2:0] {
		CLK_SYS_DIV4 = 3'h0,
		CLK_SYS = 3'h1,
		CLK_HIGH_DIV16 = 3'h2,
		CLK_HIGH_DIV64 = 3'h3,
		CLK_SUB_A = 3'h4,
		CLK_SUB_B = 3'h5,
		CLK_PIN_RISE = 3'h6,
		CLK_PIN_FALL = 3'h7
	} clk_sel_t;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_UNDEF = 2'h1,
		MODE_PWM = 2'h2,
		MODE_TIMER = 2'h3
	} mode_t;

	typedef struct packed {
		logic pause;
		clk_sel_t clk_sel;
		logic enable;
		logic [2:0] unused;
	} control_a_t;

	typedef struct packed {
		mode_t mode;
		logic [1:0] action;
		logic init_level;
		logic invert;
		logic duty_swap;
		logic clear_on_a;
	} control_b_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : compact_timer_pkg

// >>> hdl/compact_timer.sv
// compact timer: 16-bit up-counter, two comparators, compare/PWM/timer modes
// Function
// - counter compared with programmed values; match raises interrupt, may clear, drive pin
// - count clock from divided system, high clock, sub clock, or external pin
// - external pin counts on rising or falling edge as configured
// - separate interrupt outputs for comparator A and comparator P matches
// - compare mode drives pin high, low or toggles on match
// - PWM waveform appears on the same output pin
// - high bytes accessed directly, low bytes via shared 8-bit buffer
// - low write fills buffer; high write stores high and copies buffer low
// - high read returns high and latches low into buffer; low read returns buffer
// - three modes supported: compare output, timer/counter, PWM
// - core counter is 16-bit up-counter on selected clock
// - comparator P checks counter top byte; comparator A checks whole counter
// - software alters counter only by clearing via enable rising edge
// - counter clears on overflow or selected comparator match
// - counter read-only pair, compare A read/write pair, compare P single byte
// - 3-bit clock select decodes the eight documented sources
// - mode field 00 compare, 10 PWM, 11 timer; 01 undefined
// - enable rising clears counter; falling stops and keeps residual count
// - clear-select picks comparator A or comparator P/overflow as clear source outside PWM mode
`timescale 1ns/1ps
module compact_timer (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_high_clk_tick,
	input wire logic i_sub_clk_tick,
	input wire logic i_external_count_pin,
	output logic o_timer_output_pin,
	output logic o_irq_cmp_a,
	output logic o_irq_cmp_p
);

	// ==========================================================
	// register storage
	compact_timer_pkg::control_a_t control_a_r;
	compact_timer_pkg::control_b_t control_b_r;
	logic [15:0] cmp_a_r;
	logic [7:0] cmp_p_r;
	logic [7:0] hold_buf_r;
	logic [7:0] rdata_r;
	logic [15:0] count_r;
	logic enable_d_r;
	compact_timer_pkg::reg_req_t req;

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	function automatic logic hit(input compact_timer_pkg::reg_req_t r, input logic [2:0] a);
		hit = (r.addr == a);
	endfunction : hit

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			control_a_r <= compact_timer_pkg::CONTROL_A_RESET;
			control_b_r <= compact_timer_pkg::CONTROL_B_RESET;
		end else if (req.wr) begin
			if (hit(req, compact_timer_pkg::ADDR_CONTROL_A)) begin
				control_a_r <= req.wdata & compact_timer_pkg::CA_WRITE_MASK;
			end
			if (hit(req, compact_timer_pkg::ADDR_CONTROL_B)) begin
				control_b_r <= req.wdata;
			end
		end
	end

	// writes to compare registers; compare A low byte comes through the shared buffer
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cmp_a_r <= compact_timer_pkg::CMP_A_RESET;
			cmp_p_r <= compact_timer_pkg::CMP_P_RESET;
		end else if (req.wr) begin
			if (hit(req, compact_timer_pkg::ADDR_CMP_A_HIGH)) begin
				cmp_a_r <= {req.wdata, hold_buf_r};
			end
			if (hit(req, compact_timer_pkg::ADDR_CMP_P)) begin
				cmp_p_r <= req.wdata;
			end
		end
	end

	// one buffer serves both directions; a mixed sequence corrupts it by design
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_buf_r <= 8'h00;
		end else if (req.wr && hit(req, compact_timer_pkg::ADDR_CMP_A_LOW)) begin
			hold_buf_r <= req.wdata;
		end else if (req.rd && hit(req, compact_timer_pkg::ADDR_COUNT_HIGH)) begin
			hold_buf_r <= count_r[7:0];
		end else if (req.rd && hit(req, compact_timer_pkg::ADDR_CMP_A_HIGH)) begin
			hold_buf_r <= cmp_a_r[7:0];
		end
	end

	// ==========================================================
	// read port
	logic [7:0] rdata_nxt;
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (req.addr)
			compact_timer_pkg::ADDR_CONTROL_A: rdata_nxt = control_a_r;
			compact_timer_pkg::ADDR_CONTROL_B: rdata_nxt = control_b_r;
			compact_timer_pkg::ADDR_COUNT_LOW: rdata_nxt = hold_buf_r;
			compact_timer_pkg::ADDR_COUNT_HIGH: rdata_nxt = count_r[15:8];
			compact_timer_pkg::ADDR_CMP_A_LOW: rdata_nxt = hold_buf_r;
			compact_timer_pkg::ADDR_CMP_A_HIGH: rdata_nxt = cmp_a_r[15:8];
			compact_timer_pkg::ADDR_CMP_P: rdata_nxt = cmp_p_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_r <= 8'h00;
		end else if (req.rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end
	assign o_rdata = rdata_r;

	// ==========================================================
	// count clock selection
	logic [5:0] prescale_r;
	logic [5:0] high_div_r;
	logic pin_s1_r;
	logic pin_s2_r;
	logic pin_s3_r;
	logic count_tick;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prescale_r <= 6'h00;
		end else begin
			prescale_r <= prescale_r + 6'h01;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			high_div_r <= 6'h00;
		end else if (i_high_clk_tick) begin
			high_div_r <= high_div_r + 6'h01;
		end
	end

	// two-stage synchroniser, third stage only for the edge compare
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
		end else begin
			pin_s1_r <= i_external_count_pin;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	always_comb begin
		count_tick = 1'b0;
		unique case (control_a_r.clk_sel)
			compact_timer_pkg::CLK_SYS_DIV4:
				count_tick = (prescale_r[1:0] == 2'(compact_timer_pkg::SYS_DIV - 1));
			compact_timer_pkg::CLK_SYS: count_tick = 1'b1;
			compact_timer_pkg::CLK_HIGH_DIV16: count_tick = i_high_clk_tick &&
				(high_div_r[3:0] == 4'(compact_timer_pkg::HIGH_DIV_16 - 1));
			compact_timer_pkg::CLK_HIGH_DIV64: count_tick = i_high_clk_tick &&
				(high_div_r == 6'(compact_timer_pkg::HIGH_DIV_64 - 1));
			compact_timer_pkg::CLK_SUB_A: count_tick = i_sub_clk_tick;
			compact_timer_pkg::CLK_SUB_B: count_tick = i_sub_clk_tick;
			compact_timer_pkg::CLK_PIN_RISE: count_tick = pin_s2_r && !pin_s3_r;
			compact_timer_pkg::CLK_PIN_FALL: count_tick = !pin_s2_r && pin_s3_r;
		endcase
	end

	// ==========================================================
	// counter and comparators
	logic running;
	logic enable_rise;
	logic match_a;
	logic match_p;
	logic overflow;
	logic clear_now;
	logic step;

	assign running = control_a_r.enable && !control_a_r.pause;
	assign enable_rise = control_a_r.enable && !enable_d_r;
	assign step = running && count_tick;
	assign match_a = (count_r == cmp_a_r);
	assign match_p = (count_r[15:8] == cmp_p_r);
	assign overflow = (count_r == 16'hFFFF);

	// clear source; pwm runs its period on the period comparator unless duty_swap selects comparator A
	always_comb begin
		clear_now = 1'b0;
		if (control_b_r.mode == compact_timer_pkg::MODE_PWM) begin
			clear_now = control_b_r.duty_swap ? match_a : (match_p && count_r[7:0] == 8'hFF);
		end else if (control_b_r.clear_on_a) begin
			clear_now = match_a;
		end else begin
			// P matches the whole top byte: clear at its last count, so P=0 clears at 00FF
			clear_now = (match_p && count_r[7:0] == 8'hFF) ||
				(cmp_p_r == 8'h00 && overflow);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			enable_d_r <= 1'b0;
		end else begin
			enable_d_r <= control_a_r.enable;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_r <= 16'h0000;
		end else if (enable_rise) begin
			count_r <= 16'h0000;
		end else if (step) begin
			if (clear_now) begin
				count_r <= 16'h0000;
			end else begin
				count_r <= count_r + 16'h0001;
			end
		end
	end

	// flags pulse once per counter step: A on its match value, P only on the last count of its top byte
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq_cmp_a <= 1'b0;
			o_irq_cmp_p <= 1'b0;
		end else begin
			o_irq_cmp_a <= step && match_a;
			o_irq_cmp_p <= step && match_p && count_r[7:0] == 8'hFF;
		end
	end

	// ==========================================================
	// output pin
	logic out_level_r;
	logic pwm_active;
	logic [15:0] duty_val;
	logic pin_raw;

	assign duty_val = control_b_r.duty_swap ? {cmp_p_r, 8'h00} : cmp_a_r;
	assign pwm_active = (count_r < duty_val);

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_level_r <= 1'b0;
		end else if (enable_rise) begin
			out_level_r <= control_b_r.init_level;
		end else if (step && match_a &&
			control_b_r.mode == compact_timer_pkg::MODE_COMPARE) begin
			unique case (control_b_r.action)
				2'h0: out_level_r <= out_level_r;
				2'h1: out_level_r <= 1'b0;
				2'h2: out_level_r <= 1'b1;
				2'h3: out_level_r <= !out_level_r;
			endcase
		end
	end

	always_comb begin
		pin_raw = 1'b0;
		unique case (control_b_r.mode)
			compact_timer_pkg::MODE_COMPARE: pin_raw = out_level_r;
			compact_timer_pkg::MODE_PWM: begin
				unique case (control_b_r.action)
					2'h0: pin_raw = !control_b_r.init_level;
					2'h1: pin_raw = control_b_r.init_level;
					2'h2: pin_raw = control_a_r.enable ?
						(pwm_active ~^ control_b_r.init_level) : !control_b_r.init_level;
					2'h3: pin_raw = 1'b0;
				endcase
			end
			compact_timer_pkg::MODE_TIMER: pin_raw = 1'b0;
			compact_timer_pkg::MODE_UNDEF: pin_raw = 1'b0;
		endcase
	end

	logic pin_r;
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_r <= 1'b0;
		end else if (control_b_r.mode == compact_timer_pkg::MODE_TIMER) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= pin_raw ^ control_b_r.invert;
		end
	end
	assign o_timer_output_pin = pin_r;

endmodule : compact_timer

// >>> dv/compact_timer_monitor.sv
// checker: port-level relations of the compact timer
`timescale 1ns/1ps
module compact_timer_monitor (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_timer_output_pin,
	input wire logic o_irq_cmp_a,
	input wire logic o_irq_cmp_p
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// =========
	// register port
	AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data seen outside a read");
	AST_UNMAPPED: assert property (i_rd && i_addr == 3'h7 |=> o_rdata == 8'h00)
		else $error("unmapped index read nonzero");
	AST_CTRL_A: assert property (i_wr && i_addr == 3'h0 ##2 i_rd && i_addr == 3'h0
		|=> o_rdata == ($past(i_wdata, 3) & compact_timer_pkg::CA_WRITE_MASK))
		else $error("control a readback wrong");
	AST_CTRL_B: assert property (i_wr && i_addr == 3'h1 ##2 i_rd && i_addr == 3'h1
		|=> o_rdata == $past(i_wdata, 3))
		else $error("control b readback wrong");
	AST_CMP_A_HIGH: assert property (i_wr && i_addr == 3'h5 ##2 i_rd && i_addr == 3'h5
		|=> o_rdata == $past(i_wdata, 3))
		else $error("compare a high readback wrong");
	AST_CMP_P: assert property (i_wr && i_addr == 3'h6 ##2 i_rd && i_addr == 3'h6
		|=> o_rdata == $past(i_wdata, 3))
		else $error("compare p readback wrong");
	// =========
	// outputs
	AST_TIMER_PIN: assert property (
		i_wr && i_addr == 3'h1 && i_wdata[7:6] == 2'h3 |-> ##3 !o_timer_output_pin)
		else $error("pin driven in timer mode");
	AST_RESET_QUIET: assert property ($rose(i_reset_n)
		|-> !o_irq_cmp_a && !o_irq_cmp_p && !o_timer_output_pin && o_rdata == 8'h00)
		else $error("outputs active after reset");
endmodule : compact_timer_monitor

bind compact_timer compact_timer_monitor i_mon (.i_sys_clk(i_sys_clk),
	.i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_timer_output_pin(o_timer_output_pin),
	.o_irq_cmp_a(o_irq_cmp_a), .o_irq_cmp_p(o_irq_cmp_p));

// >>> dv/compact_timer_partner.sv
// partner: external event source on the count pin
`timescale 1ns/1ps
module compact_timer_partner (
	input wire logic i_sys_clk,
	output logic o_count_pin
);
	initial o_count_pin = 1'b0;
	// whole pulses only, so rising and falling counts agree
	task automatic send_pulses(input int n, input int half);
		for (int k = 0; k < 2 * n; k++) begin
			o_count_pin <= ~o_count_pin;
			repeat (half) @(posedge i_sys_clk);
		end
	endtask : send_pulses
endmodule : compact_timer_partner

// >>> dv/test_compact_timer.sv
// testbench: registers, counting, comparators and pin of the compact timer
`timescale 1ns/1ps
module test_compact_timer;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic hi_t = 1'b0;
	logic sub_t = 1'b0;
	logic [1:0] sub_c = 2'h0;
	logic [7:0] rdata;
	logic pin, ext, irq_a, irq_p;
	int miscompares = 0;
	int check_count = 0;
	int unsigned seed = 79;
	int hi_cnt;
	int sels[5] = '{0, 1, 2, 4, 5};
	int divs[5] = '{4, 1, 32, 4, 4};
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		hi_t <= ~hi_t;
		sub_c <= sub_c + 2'h1;
		sub_t <= (sub_c == 2'h3);
	end
	compact_timer i_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
		.i_high_clk_tick(hi_t), .i_sub_clk_tick(sub_t), .i_external_count_pin(ext),
		.o_timer_output_pin(pin), .o_irq_cmp_a(irq_a), .o_irq_cmp_p(irq_p));
	compact_timer_partner i_part (.i_sys_clk(clk), .o_count_pin(ext));
	// =========
	// helpers
	function automatic int unsigned nxt_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : nxt_rand
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
		check_count++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask : chk
	// gap cycle after a write so the strobe is never set twice in one step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask : rd
	task automatic rd16(input logic [2:0] a, output logic [15:0] v);
		rd(a, v[15:8]);
		rd(a - 3'h1, v[7:0]);
	endtask : rd16
	task automatic wait_irq(input bit on_p, output int n);
		n = 0;
		hi_cnt = 0;
		do begin
			@(posedge clk);
			n++;
			hi_cnt += int'(pin === 1'b1);
		end while ((on_p ? irq_p : irq_a) !== 1'b1 && n < 40000);
		if (n >= 40000) begin
			miscompares++;
			tally_and_finish();
		end
	endtask : wait_irq
	// =========
	// main sequence
	initial begin
		logic [7:0] d;
		logic [15:0] w;
		int n, c;
		int unsigned v;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), d);
			chk("reset value", d, 16'h0000);
		end
		v = nxt_rand();
		wr(3'h0, v[7:0] & 8'hF7);
		rd(3'h0, d);
		chk("control a", d, v[7:0] & 8'hF0);
		wr(3'h1, v[15:8]);
		rd(3'h1, d);
		chk("control b", d, v[15:8]);
		wr(3'h4, v[23:16]);
		wr(3'h5, v[31:24]);
		rd16(3'h5, w);
		chk("compare a", w, v[31:16]);
		wr(3'h4, ~v[23:16]);
		rd16(3'h5, w);
		chk("compare a low alone", w, v[31:16]);
		wr(3'h6, v[7:0]);
		rd(3'h6, d);
		chk("compare p", d, v[7:0]);
		wr(3'h3, 8'hFF);
		wr(3'h2, 8'hFF);
		wr(3'h7, 8'hFF);
		rd16(3'h3, w);
		chk("count after writes", w, 16'h0000);
		$display("test registers done");
		wr(3'h1, 8'hC0);
		for (int s = 6; s < 8; s++) begin
			n = 3 + nxt_rand() % 8;
			wr(3'h0, 8'(s << 4));
			wr(3'h0, 8'(s << 4) | 8'h08);
			i_part.send_pulses(n, 3);
			repeat (4) @(posedge clk);
			rd16(3'h3, w);
			chk("pin count", w, 16'(n));
			wr(3'h0, 8'(s << 4) | 8'h88);
			i_part.send_pulses(2, 3);
			wr(3'h0, 8'(s << 4));
			i_part.send_pulses(2, 3);
			repeat (4) @(posedge clk);
			rd16(3'h3, w);
			chk("held count", w, 16'(n));
		end
		$display("test pin counting done");
		c = nxt_rand() % 510;
		wr(3'h6, 8'h01);
		wr(3'h4, 8'(c));
		wr(3'h5, 8'(c >> 8));
		for (int i = 0; i < 5; i++) begin
			wr(3'h0, 8'h00);
			wr(3'h0, 8'(sels[i] << 4) | 8'h08);
			wait_irq(1'b1, n);
			wait_irq(1'b0, n);
			chk("p to a cycles", 16'(n), 16'((c + 1) * divs[i]));
			wait_irq(1'b1, n);
			chk("a to p cycles", 16'(n), 16'((511 - c) * divs[i]));
		end
		wr(3'h1, 8'hC1);
		wr(3'h0, 8'h00);
		wr(3'h0, 8'h18);
		wait_irq(1'b0, n);
		wait_irq(1'b0, n);
		chk("clear on a", 16'(n), 16'(c + 1));
		$display("test comparators done");
		c = 12 + nxt_rand() % 20;
		wr(3'h4, 8'(c));
		wr(3'h5, 8'h00);
		for (int act = 1; act < 4; act++) begin
			wr(3'h0, 8'h00);
			wr(3'h1, 8'((act << 4) | ((act == 1) << 3) | 1));
			wr(3'h0, 8'h18);
			repeat (3) @(posedge clk);
			chk("pin initial", pin, act == 1);
			wait_irq(1'b0, n);
			repeat (3) @(posedge clk);
			chk("pin first match", pin, act != 1);
			wait_irq(1'b0, n);
			repeat (3) @(posedge clk);
			chk("pin second match", pin, act == 2);
		end
		$display("test compare output done");
		c = 16 + nxt_rand() % 400;
		wr(3'h0, 8'h00);
		wr(3'h1, 8'hA8);
		wr(3'h4, 8'(c));
		wr(3'h5, 8'(c >> 8));
		wr(3'h0, 8'h18);
		wait_irq(1'b1, n);
		wait_irq(1'b1, n);
		chk("pwm period", 16'(n), 16'h0200);
		chk("pwm high cycles", 16'(hi_cnt), 16'(c));
		$display("test pwm done");
		tally_and_finish();
	end
endmodule : test_compact_timer
